//--- pcb_branch_unit.sv
// Program control sequencing: jump, test, bit compare, execute,
// index modify with branch, halt; APB status and control.
// Assumes fetch logic supplies decoded class, selector characters and
// the final effective address; console buttons arrive unsynchronised.
`timescale 1ns/1ps
`include "pcb_params.svh"

module pcb_branch_unit (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  output logic instr_ready,
  input pcb_pkg::pcb_op_t instr_op,
  input wire logic [`PCB_CW-1:0] instr_z,
  input wire logic [`PCB_CW-1:0] instr_y,
  input wire logic [`PCB_AW-1:0] eff_addr,
  input wire logic [`PCB_AW-1:0] seq_addr,
  input wire logic [`PCB_WW-1:0] accum,
  input wire logic [`PCB_WW-1:0] mem_operand,
  input wire logic test_line,
  input wire logic other_jump,
  output logic [2*`PCB_CW-1:0] test_sel,
  output logic done,
  output logic [`PCB_AW-1:0] next_addr,
  output logic jumped,
  output logic strip_options,
  output logic cmp_equal,
  output logic cmp_equal_compl,
  output logic halted,
  input wire logic [`PCB_BP_COUNT-1:0] bp_switch_pin,
  input wire logic start_pin,
  input wire logic step_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int PIN_W = `PCB_BP_COUNT + 2;

  pcb_pkg::pcb_state_t state_reg;
  pcb_pkg::pcb_state_t state_next;
  logic [`PCB_CW-1:0] ir_z_reg;
  logic [`PCB_CW-1:0] ir_y_reg;
  logic [`PCB_AW-1:0] ea_reg;
  logic [`PCB_AW-1:0] seq_reg;
  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;
  logic [PIN_W-1:0] pin_s3_reg;
  logic [PIN_W-1:0] pin_val_reg;
  logic [PIN_W-1:0] pin_prev_reg;
  logic exec_pending_reg;
  logic exec_follow_reg;
  logic [`PCB_AW-1:0] ret_addr_reg;
  logic done_reg;
  logic jumped_reg;
  logic [`PCB_AW-1:0] next_addr_reg;
  logic cmp_eq_reg;
  logic cmp_cp_reg;
  logic bp_enable_reg;
  logic sw_start_reg;
  logic [31:0] prdata_reg;
  logic accept;
  logic resume;
  logic fin_valid;
  logic fin_taken;
  logic [`PCB_AW-1:0] fin_target;
  logic [`PCB_AW-1:0] fin_seq;
  logic launch;
  logic cmp_load;
  logic cmp_eq_next;
  logic cmp_cp_next;
  logic [`PCB_CW-1:0] tb_char;
  logic [`PCB_CW-1:0] cmp_diff;
  logic halt_cond;
  logic sel_ok;
  logic in_range;
  logic signed [`PCB_AW+1:0] xr_sum;
  logic signed [`PCB_CW-1:0] inc_val;
  logic [`PCB_CW-1:0] bp_idx;
  logic apb_wr;
  logic apb_mapped;

  pcb_xr_if xr ();

  pcb_xr_mem u_xr_mem (
    .clk(clk),
    .reset(reset),
    .xr(xr.mem)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [`PCB_CW-1:0] char_at(input logic [`PCB_WW-1:0] w,
                                                 input logic [`PCB_CW-1:0] c);
    char_at = w[c[2:0]*`PCB_CW +: `PCB_CW];
  endfunction

  function automatic logic signed [`PCB_CW-1:0] inc_of(input logic [`PCB_CW-1:0] y);
    logic [`PCB_CW-1:0] mag;
    mag = (y[3:0] > `PCB_INC_MAX) ? '0 : {2'h0, y[3:0]};
    inc_of = y[`PCB_SIGN_BIT] ? -$signed(mag) : $signed(mag);
  endfunction

  function automatic logic [`PCB_XR_AW-1:0] xr_slot(input logic [`PCB_CW-1:0] z);
    xr_slot = z[`PCB_XR_AW-1:0] - 5'h01;
  endfunction

  // ----------------------------------------
  // Console pins: three stages, accepted when stages two and three agree
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
      pin_val_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      pin_s1_reg <= {step_pin, start_pin, bp_switch_pin};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_val_reg <= (~(pin_s2_reg ^ pin_s3_reg) & pin_s3_reg)
        | ((pin_s2_reg ^ pin_s3_reg) & pin_val_reg);
      pin_prev_reg <= pin_val_reg;
    end
  end

  // Start and step both count on the press, not while held
  assign resume = (state_reg == pcb_pkg::PCB_ST_HALTED) && (sw_start_reg
    || (pin_val_reg[PIN_W-2] && !pin_prev_reg[PIN_W-2])
    || (pin_val_reg[PIN_W-1] && !pin_prev_reg[PIN_W-1]));

  // ----------------------------------------
  // Decode and decision
  // ----------------------------------------
  assign instr_ready = (state_reg == pcb_pkg::PCB_ST_IDLE);
  assign accept = instr_valid && instr_ready;
  assign test_sel = {instr_z, instr_y};
  assign tb_char = char_at(accum, instr_z);
  assign cmp_diff = (tb_char ^ char_at(mem_operand, instr_z)) & instr_y;
  assign bp_idx = instr_y - `PCB_BP_Y_FIRST;
  assign halt_cond = (instr_z == `PCB_HALT_Z) && ((instr_y == `PCB_HALT_Y)
    || (bp_idx < `PCB_BP_COUNT && bp_enable_reg
    && pin_val_reg[bp_idx[3:0]]));
  assign sel_ok = (ir_z_reg[`PCB_XR_AW-1:0] != '0)
    && (ir_z_reg[`PCB_XR_AW-1:0] <= `PCB_XR_COUNT);
  assign inc_val = inc_of(ir_y_reg);
  assign xr_sum = $signed({2'h0, xr.rd_data})
    + $signed({{(`PCB_AW-4){inc_val[`PCB_CW-1]}}, inc_val});
  assign in_range = !xr_sum[`PCB_AW+1] && !xr_sum[`PCB_AW]
    && (xr_sum[`PCB_AW-1:0] <= `PCB_MEM_LIMIT);

  always_comb begin
    state_next = state_reg;
    fin_valid = 1'b0;
    fin_taken = 1'b0;
    fin_target = ea_reg;
    fin_seq = seq_reg;
    launch = 1'b0;
    cmp_load = 1'b0;
    cmp_eq_next = cmp_eq_reg;
    cmp_cp_next = cmp_cp_reg;
    case (state_reg)
      pcb_pkg::PCB_ST_IDLE: begin
        fin_target = eff_addr;
        fin_seq = seq_addr;
        if (accept) begin
          case (instr_op)
            pcb_pkg::PCB_OP_NOP: begin
              fin_valid = 1'b1;
            end
            pcb_pkg::PCB_OP_JUMP: begin
              fin_valid = 1'b1;
              fin_taken = 1'b1;
            end
            pcb_pkg::PCB_OP_TEST: begin
              fin_valid = 1'b1;
              fin_taken = (test_line == instr_y[`PCB_SIGN_BIT]);
            end
            pcb_pkg::PCB_OP_BITCMP: begin
              fin_valid = 1'b1;
              if (!instr_z[`PCB_MODE_BIT]) begin
                fin_taken = (instr_z[3:0] <= `PCB_CHAR_POS_MAX)
                  && (instr_y[3:0] != 4'h0) && (instr_y[3:0] <= `PCB_BIT_POS_MAX)
                  && tb_char[instr_y[2:0] - 3'h1];
              end else begin
                cmp_load = 1'b1;
                cmp_eq_next = (cmp_diff == '0);
                cmp_cp_next = (cmp_diff == instr_y);
              end
            end
            pcb_pkg::PCB_OP_EXEC: begin
              launch = 1'b1;
            end
            pcb_pkg::PCB_OP_INDEX: begin
              state_next = pcb_pkg::PCB_ST_XR_CALC;
            end
            pcb_pkg::PCB_OP_HALT: begin
              if (halt_cond) begin
                state_next = pcb_pkg::PCB_ST_HALTED;
              end else begin
                fin_valid = 1'b1;
              end
            end
            default: begin
              fin_valid = 1'b1;
              fin_taken = other_jump;
            end
          endcase
        end
      end
      pcb_pkg::PCB_ST_XR_CALC: begin
        fin_valid = 1'b1;
        fin_taken = sel_ok && in_range;
        state_next = pcb_pkg::PCB_ST_IDLE;
      end
      pcb_pkg::PCB_ST_HALTED: begin
        if (resume) begin
          fin_valid = 1'b1;
          fin_taken = 1'b1;
          state_next = pcb_pkg::PCB_ST_IDLE;
        end
      end
      default: begin
        state_next = pcb_pkg::PCB_ST_IDLE;
      end
    endcase
  end

  // Index file traffic; out-of-range results leave the register unchanged
  assign xr.rd_en = accept && (instr_op == pcb_pkg::PCB_OP_INDEX);
  assign xr.rd_addr = xr_slot(instr_z);
  assign xr.wr_en = (state_reg == pcb_pkg::PCB_ST_XR_CALC) && sel_ok && in_range;
  assign xr.wr_addr = xr_slot(ir_z_reg);
  assign xr.wr_data = xr_sum[`PCB_AW-1:0];

  // ----------------------------------------
  // State and latched instruction fields
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= pcb_pkg::PCB_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ir_z_reg <= '0;
      ir_y_reg <= '0;
      ea_reg <= '0;
      seq_reg <= '0;
    end else if (accept) begin
      ir_z_reg <= instr_z;
      ir_y_reg <= instr_y;
      ea_reg <= eff_addr;
      seq_reg <= seq_addr;
    end
  end

  // ----------------------------------------
  // Execute tracking
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      exec_pending_reg <= 1'b0;
      exec_follow_reg <= 1'b0;
      ret_addr_reg <= '0;
    end else if (launch) begin
      exec_pending_reg <= 1'b1;
      exec_follow_reg <= instr_z[`PCB_MODE_BIT];
      ret_addr_reg <= seq_addr;
    end else if (fin_valid) begin
      exec_pending_reg <= 1'b0;
    end
  end

  // Fetch must drop modify and flag-return options while this is high
  assign strip_options = exec_pending_reg;

  // ----------------------------------------
  // Completion outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      done_reg <= 1'b0;
      jumped_reg <= 1'b0;
      next_addr_reg <= '0;
    end else begin
      done_reg <= fin_valid || launch;
      if (launch) begin
        jumped_reg <= 1'b1;
        next_addr_reg <= eff_addr;
      end else if (fin_valid) begin
        jumped_reg <= fin_taken;
        if (exec_pending_reg) begin
          next_addr_reg <= (exec_follow_reg && fin_taken) ? fin_target
            : ret_addr_reg;
        end else begin
          next_addr_reg <= fin_taken ? fin_target : fin_seq;
        end
      end
    end
  end

  assign done = done_reg;
  assign jumped = jumped_reg;
  assign next_addr = next_addr_reg;
  assign halted = (state_reg == pcb_pkg::PCB_ST_HALTED);

  // ----------------------------------------
  // Compare flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      cmp_eq_reg <= 1'b0;
      cmp_cp_reg <= 1'b0;
    end else if (cmp_load) begin
      cmp_eq_reg <= cmp_eq_next;
      cmp_cp_reg <= cmp_cp_next;
    end
  end

  assign cmp_equal = cmp_eq_reg;
  assign cmp_equal_compl = cmp_cp_reg;

  // ----------------------------------------
  // APB slave: zero wait, read data captured in the setup cycle
  // ----------------------------------------
  assign apb_mapped = (paddr == `PCB_OFF_STATUS) || (paddr == `PCB_OFF_CTRL)
    || (paddr == `PCB_OFF_NEXT);
  assign apb_wr = psel && penable && pwrite && apb_mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !apb_mapped;
  assign prdata = prdata_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      bp_enable_reg <= `PCB_CTRL_RST;
      sw_start_reg <= 1'b0;
    end else begin
      sw_start_reg <= apb_wr && (paddr == `PCB_OFF_CTRL) && pwdata[`PCB_CTRL_START];
      if (apb_wr && (paddr == `PCB_OFF_CTRL)) begin
        bp_enable_reg <= pwdata[`PCB_CTRL_BPEN];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_reg <= '0;
    end else if (psel && !penable) begin
      case (paddr)
        `PCB_OFF_STATUS: prdata_reg <= {27'h0, exec_follow_reg, exec_pending_reg,
          halted, cmp_cp_reg, cmp_eq_reg};
        `PCB_OFF_CTRL: prdata_reg <= {31'h0, bp_enable_reg};
        `PCB_OFF_NEXT: prdata_reg <= {15'h0, next_addr_reg};
        default: prdata_reg <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_jump_target: assert property (
    accept && instr_op == pcb_pkg::PCB_OP_JUMP && !exec_pending_reg
    |=> done && jumped && next_addr == $past(eff_addr))
    else $error("jump did not go to operand address");

  a_nop_sequential: assert property (
    accept && instr_op == pcb_pkg::PCB_OP_NOP && !exec_pending_reg
    |=> done && !jumped && next_addr == $past(seq_addr))
    else $error("no-op did not advance sequentially");

  a_test_polarity: assert property (
    accept && instr_op == pcb_pkg::PCB_OP_TEST
    |=> jumped == ($past(test_line) == $past(instr_y[`PCB_SIGN_BIT])))
    else $error("test branch polarity wrong");

  a_char_flags: assert property (
    accept && instr_op == pcb_pkg::PCB_OP_BITCMP && instr_z[`PCB_MODE_BIT]
    && instr_y == '0 |=> cmp_equal && cmp_equal_compl && !jumped)
    else $error("empty mask did not set both flags");

  a_exec_return: assert property (
    fin_valid && exec_pending_reg && !exec_follow_reg
    |=> done && next_addr == $past(ret_addr_reg))
    else $error("execute did not return");

  a_exec_strip: assert property (
    launch |=> strip_options until done)
    else $error("options not stripped during execute");

  a_index_bound: assert property (
    xr.wr_en |-> xr.wr_data <= `PCB_MEM_LIMIT ##1 done && jumped)
    else $error("index result out of range written");

  a_index_latency: assert property (
    xr.rd_en |=> !done ##1 done)
    else $error("index modify latency wrong");

  a_halt_stops: assert property (
    accept && instr_op == pcb_pkg::PCB_OP_HALT && instr_z == `PCB_HALT_Z
    && instr_y == `PCB_HALT_Y |=> halted && !done)
    else $error("unconditional halt did not stop");

  a_resume_target: assert property (
    resume && !exec_pending_reg |=> done && !halted && next_addr == $past(ea_reg))
    else $error("resume address wrong");

  c_index_branch: cover property (xr.wr_en ##1 done && jumped);
  c_exec_follow: cover property (launch && instr_z[`PCB_MODE_BIT] ##[1:20] done && jumped);
  c_halt_resume: cover property (halted ##[1:50] resume);
  c_mixed_compare: cover property (cmp_load && !cmp_eq_next && !cmp_cp_next);

endmodule

//--- pcb_params.svh
// Constants of the program control branch unit: widths, codes, offsets.
// Assumes a 40 MHz single clock and APB register access.
`ifndef PCB_PARAMS_SVH
`define PCB_PARAMS_SVH

// ----------------------------------------
// Word and character layout
// ----------------------------------------
`define PCB_CW 6
`define PCB_WW 48
`define PCB_AW 17
`define PCB_MODE_BIT 4
`define PCB_SIGN_BIT 5
`define PCB_CHAR_POS_MAX 4'h7
`define PCB_BIT_POS_MAX 4'h6

// ----------------------------------------
// Index registers
// ----------------------------------------
`define PCB_XR_AW 5
`define PCB_XR_COUNT 5'h11
`define PCB_INC_MAX 4'h9
`define PCB_MEM_LIMIT 17'h0F9FF

// ----------------------------------------
// Halt selector codes
// ----------------------------------------
`define PCB_HALT_Z 6'h05
`define PCB_HALT_Y 6'h3B
`define PCB_BP_Y_FIRST 6'h21
`define PCB_BP_COUNT 9

// ----------------------------------------
// Register map
// ----------------------------------------
`define PCB_OFF_STATUS 8'h00
`define PCB_OFF_CTRL 8'h04
`define PCB_OFF_NEXT 8'h08
`define PCB_CTRL_BPEN 0
`define PCB_CTRL_START 1
`define PCB_CTRL_RST 1'h1

`endif

//--- pcb_pkg.sv
// Types of the program control branch unit.
// Assumes pcb_params.svh supplies the numeric constants.

package pcb_pkg;

  // ----------------------------------------
  // Instruction classes seen by the unit
  // ----------------------------------------
  typedef enum logic [2:0] {
    PCB_OP_NOP,
    PCB_OP_JUMP,
    PCB_OP_TEST,
    PCB_OP_BITCMP,
    PCB_OP_EXEC,
    PCB_OP_INDEX,
    PCB_OP_HALT,
    PCB_OP_OTHER
  } pcb_op_t;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    PCB_ST_IDLE,
    PCB_ST_XR_CALC,
    PCB_ST_HALTED
  } pcb_state_t;

endpackage

//--- pcb_xr_if.sv
// Index register file port between sequencer and storage.
// Assumes one clock; read data one cycle after the read strobe.
`timescale 1ns/1ps
`include "pcb_params.svh"

interface pcb_xr_if;
  logic rd_en;
  logic [`PCB_XR_AW-1:0] rd_addr;
  logic [`PCB_AW-1:0] rd_data;
  logic wr_en;
  logic [`PCB_XR_AW-1:0] wr_addr;
  logic [`PCB_AW-1:0] wr_data;

  modport seq (output rd_en, output rd_addr, input rd_data,
    output wr_en, output wr_addr, output wr_data);
  modport mem (input rd_en, input rd_addr, output rd_data,
    input wr_en, input wr_addr, input wr_data);
endinterface

//--- pcb_xr_mem.sv
// Seventeen index registers with a registered read port.
// Assumes the caller keeps addresses below the register count.
`timescale 1ns/1ps
`include "pcb_params.svh"

module pcb_xr_mem (
  input wire logic clk,
  input wire logic reset,
  pcb_xr_if.mem xr
);

  logic [`PCB_AW-1:0] store_reg [`PCB_XR_COUNT];
  logic [`PCB_AW-1:0] rd_data_reg;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `PCB_XR_COUNT; i++) begin
        store_reg[i] <= '0;
      end
    end else if (xr.wr_en) begin
      store_reg[xr.wr_addr] <= xr.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_reg <= '0;
    end else if (xr.rd_en) begin
      rd_data_reg <= store_reg[xr.rd_addr];
    end
  end

  assign xr.rd_data = rd_data_reg;

endmodule

//--- pcb_console_model.sv
// Control console model: start, step and breakpoint switch pins.
// Assumes the bench asks for presses one cycle long; a press is stretched.
`timescale 1ns/1ps

module pcb_console_model #(
  parameter int HOLD = 6
) (
  input wire logic clk,
  input wire logic press_start,
  input wire logic press_step,
  input wire logic [8:0] bp_on,
  output logic start_pin,
  output logic step_pin,
  output logic [8:0] bp_switch_pin
);
  // ----------------------------------------
  // Buttons
  // ----------------------------------------
  // A real finger holds a button for many cycles; released buttons read low
  int start_cnt = 0;
  int step_cnt = 0;

  always_ff @(posedge clk) begin
    start_cnt <= press_start ? HOLD : (start_cnt > 0 ? start_cnt - 1 : 0);
  end

  always_ff @(posedge clk) begin
    step_cnt <= press_step ? HOLD : (step_cnt > 0 ? step_cnt - 1 : 0);
  end

  assign start_pin = (start_cnt > 0);
  assign step_pin = (step_cnt > 0);
  assign bp_switch_pin = bp_on;
endmodule

//--- tb_program_control_branch_unit.sv
// Self-checking bench for the program control branch unit.
// Assumes the console model drives the button and breakpoint pins.
`timescale 1ns/1ps
`include "pcb_params.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module tb_program_control_branch_unit;
  typedef struct {pcb_pkg::pcb_op_t op; logic [5:0] z; logic [5:0] y; logic ln;
    logic [47:0] a; logic [47:0] m; logic j; logic [1:0] f;} pcb_row_t;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic instr_valid = 1'h0;
  pcb_pkg::pcb_op_t instr_op = pcb_pkg::PCB_OP_NOP;
  logic [5:0] instr_z = 6'h00;
  logic [5:0] instr_y = 6'h00;
  logic [16:0] eff_addr = 17'h00000;
  logic [16:0] seq_addr = 17'h00000;
  logic [47:0] accum = 48'h0;
  logic [47:0] mem_operand = 48'h0;
  logic test_line = 1'h0;
  logic other_jump = 1'h0;
  logic press_start = 1'h0;
  logic press_step = 1'h0;
  logic [8:0] bp_on = 9'h000;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic instr_ready, done, jumped, strip_options, cmp_equal, cmp_equal_compl, halted;
  logic start_pin, step_pin, pready, pslverr, got_j, err;
  logic [11:0] test_sel;
  logic [16:0] next_addr, got_next;
  logic [8:0] bp_switch_pin;
  logic [31:0] prdata, rd;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  pcb_row_t rows[12];

  always #12.5 clk = ~clk;

  pcb_console_model i_console (.clk(clk), .press_start(press_start), .press_step(press_step),
    .bp_on(bp_on), .start_pin(start_pin), .step_pin(step_pin), .bp_switch_pin(bp_switch_pin));

  pcb_branch_unit i_dut (.clk(clk), .reset(reset), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_op(instr_op), .instr_z(instr_z), .instr_y(instr_y),
    .eff_addr(eff_addr), .seq_addr(seq_addr), .accum(accum), .mem_operand(mem_operand),
    .test_line(test_line), .other_jump(other_jump), .test_sel(test_sel), .done(done),
    .next_addr(next_addr), .jumped(jumped), .strip_options(strip_options),
    .cmp_equal(cmp_equal), .cmp_equal_compl(cmp_equal_compl), .halted(halted),
    .bp_switch_pin(bp_switch_pin), .start_pin(start_pin), .step_pin(step_pin),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------
  // Closing and hang guard
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Drivers, entered just after a rising edge
  // ----------------------------------------
  task automatic issue(input pcb_pkg::pcb_op_t op, input logic [5:0] z, input logic [5:0] y,
    input logic [16:0] ea, input logic [16:0] sa);
    logic r;
    instr_valid <= 1'h1;
    instr_op <= op;
    instr_z <= z;
    instr_y <= y;
    eff_addr <= ea;
    seq_addr <= sa;
    // Ready is looked at mid-cycle, where it has settled before the taking edge
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge clk);
      r = instr_ready;
      @(posedge clk);
    end
    instr_valid <= 1'h0;
  endtask

  task automatic wait_done;
    do @(negedge clk); while (done !== 1'b1);
    got_next = next_addr;
    got_j = jumped;
    @(posedge clk);
  endtask

  task automatic run(input pcb_pkg::pcb_op_t op, input logic [5:0] z, input logic [5:0] y,
    input logic [16:0] ea, input logic [16:0] sa, input logic [16:0] exp_next);
    issue(op, z, y, ea, sa);
    wait_done();
    `CHK(got_next, exp_next)
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  // Stop, look at status, release with start or step, expect the operand address
  task automatic halt_case(input logic [5:0] y, input logic [16:0] ea, input logic use_step);
    issue(pcb_pkg::PCB_OP_HALT, 6'h05, y, ea, 17'h00099);
    repeat (3) @(posedge clk);
    `CHK(halted, 1'b1)
    apb(1'h0, 8'h00, 32'h0);
    `CHK(rd[2], 1'b1)
    press_start <= !use_step;
    press_step <= use_step;
    @(posedge clk);
    press_start <= 1'h0;
    press_step <= 1'h0;
    wait_done();
    `CHK(got_next, ea)
    @(posedge clk);
    `CHK(halted, 1'b0)
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{
      '{pcb_pkg::PCB_OP_NOP, 6'h00, 6'h00, 1'h0, 48'h0, 48'h0, 1'h0, 2'h0},
      '{pcb_pkg::PCB_OP_JUMP, 6'h3F, 6'h3F, 1'h0, 48'h0, 48'h0, 1'h1, 2'h0},
      '{pcb_pkg::PCB_OP_TEST, 6'h12, 6'h00, 1'h0, 48'h0, 48'h0, 1'h1, 2'h0},
      '{pcb_pkg::PCB_OP_TEST, 6'h12, 6'h00, 1'h1, 48'h0, 48'h0, 1'h0, 2'h0},
      '{pcb_pkg::PCB_OP_TEST, 6'h12, 6'h20, 1'h1, 48'h0, 48'h0, 1'h1, 2'h0},
      '{pcb_pkg::PCB_OP_TEST, 6'h12, 6'h20, 1'h0, 48'h0, 48'h0, 1'h0, 2'h0},
      '{pcb_pkg::PCB_OP_BITCMP, 6'h02, 6'h03, 1'h0, 48'h4000, 48'h0, 1'h1, 2'h0},
      '{pcb_pkg::PCB_OP_BITCMP, 6'h02, 6'h03, 1'h0, 48'hFFFFFFFFBFFF, 48'h0, 1'h0, 2'h0},
      '{pcb_pkg::PCB_OP_BITCMP, 6'h11, 6'h0F, 1'h0, 48'h280, 48'hFFFFFFF2BF, 1'h0, 2'h1},
      '{pcb_pkg::PCB_OP_BITCMP, 6'h11, 6'h3F, 1'h0, 48'h280, 48'hD40, 1'h0, 2'h2},
      '{pcb_pkg::PCB_OP_BITCMP, 6'h11, 6'h3F, 1'h0, 48'h280, 48'h0, 1'h0, 2'h0},
      '{pcb_pkg::PCB_OP_BITCMP, 6'h11, 6'h00, 1'h0, 48'h280, 48'h0, 1'h0, 2'h3}};
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    `CHK({done, halted, instr_ready, next_addr}, 20'h20000)
    for (int i = 0; i < 12; i++) begin
      test_line <= rows[i].ln;
      accum <= rows[i].a;
      mem_operand <= rows[i].m;
      run(rows[i].op, rows[i].z, rows[i].y, 17'h00100 + 17'(i), 17'h00050 + 17'(i),
        rows[i].j ? 17'h00100 + 17'(i) : 17'h00050 + 17'(i));
      `CHK(got_j, rows[i].j)
      `CHK(test_sel, {rows[i].z, rows[i].y})
      if (rows[i].op == pcb_pkg::PCB_OP_BITCMP && rows[i].z[4])
        `CHK({cmp_equal_compl, cmp_equal}, rows[i].f)
    end
    // Index steps: +3 from zero, then -4 falls below zero, then a bad magnitude
    run(pcb_pkg::PCB_OP_INDEX, 6'h01, 6'h03, 17'h00200, 17'h00060, 17'h00200);
    run(pcb_pkg::PCB_OP_INDEX, 6'h01, 6'h24, 17'h00201, 17'h00061, 17'h00061);
    run(pcb_pkg::PCB_OP_INDEX, 6'h01, 6'h2C, 17'h00202, 17'h00062, 17'h00202);
    run(pcb_pkg::PCB_OP_INDEX, 6'h11, 6'h09, 17'h00203, 17'h00063, 17'h00203);
    run(pcb_pkg::PCB_OP_INDEX, 6'h12, 6'h01, 17'h00204, 17'h00064, 17'h00064);
    `CHK(got_j, 1'b0)
    run(pcb_pkg::PCB_OP_INDEX, 6'h00, 6'h01, 17'h00205, 17'h00065, 17'h00065);
    // Execute: return always, follow jump, and no jump to follow
    run(pcb_pkg::PCB_OP_EXEC, 6'h00, 6'h00, 17'h00300, 17'h00040, 17'h00300);
    `CHK(strip_options, 1'b1)
    run(pcb_pkg::PCB_OP_JUMP, 6'h00, 6'h00, 17'h00310, 17'h00077, 17'h00040);
    run(pcb_pkg::PCB_OP_EXEC, 6'h10, 6'h00, 17'h00320, 17'h00041, 17'h00320);
    run(pcb_pkg::PCB_OP_JUMP, 6'h00, 6'h00, 17'h00330, 17'h00078, 17'h00330);
    @(posedge clk);
    `CHK(strip_options, 1'b0)
    run(pcb_pkg::PCB_OP_EXEC, 6'h10, 6'h00, 17'h00340, 17'h00042, 17'h00340);
    other_jump <= 1'h1;
    run(pcb_pkg::PCB_OP_OTHER, 6'h00, 6'h00, 17'h00350, 17'h00079, 17'h00350);
    other_jump <= 1'h0;
    run(pcb_pkg::PCB_OP_EXEC, 6'h10, 6'h00, 17'h00360, 17'h00043, 17'h00360);
    run(pcb_pkg::PCB_OP_NOP, 6'h00, 6'h00, 17'h00370, 17'h0007A, 17'h00043);
    // Halts: unconditional, breakpoint on, breakpoint off, unknown code
    halt_case(6'h3B, 17'h00400, 1'h0);
    bp_on <= 9'h004;
    repeat (5) @(posedge clk);
    halt_case(6'h23, 17'h00410, 1'h1);
    bp_on <= 9'h000;
    repeat (5) @(posedge clk);
    run(pcb_pkg::PCB_OP_HALT, 6'h05, 6'h23, 17'h00420, 17'h00091, 17'h00091);
    run(pcb_pkg::PCB_OP_HALT, 6'h05, 6'h00, 17'h00430, 17'h00092, 17'h00092);
    // Register side: next address readback, unmapped place refused
    apb(1'h0, 8'h08, 32'h0);
    `CHK(rd, {15'h0000, got_next})
    apb(1'h1, 8'h0C, 32'hFFFFFFFF);
    `CHK(err, 1'b1)
    apb(1'h0, 8'h0C, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    report_and_stop();
  end
endmodule
